//--- obph_pkg.sv
// shared constants and crc helper for the optical bus port pair
package obph_pkg;
  localparam int CLK_NS = 100;
  localparam int SYNC_NS = 4000;
  localparam int CTRL_NS = 1840;
  localparam int DATA_NS = 20480;
  // slots round down so a frame never runs long
  localparam int SYNC_CYC = SYNC_NS / CLK_NS;
  localparam int CTRL_CYC = CTRL_NS / CLK_NS;
  localparam int DATA_CYC = DATA_NS / CLK_NS;
  localparam int BLK_BITS = 2048;
  localparam int LW = 16;
  localparam int BLK_WORDS = BLK_BITS / LW;
  localparam int UW = 32;
  localparam int CMD_BYTES = 16384;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [1:0] SC_NONE = 2'h0;
  localparam logic [1:0] SC_CTRL = 2'h1;
  localparam logic [1:0] SC_DATA = 2'h2;
  localparam logic CLS_SHARED = 1'h1;
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_TX = 2'h1;
  localparam logic [1:0] CMD_RX = 2'h2;
  localparam int CW_CMD_LSB = 0;
  localparam int CW_WID_LSB = 2;
  localparam logic [4:0] WID_RST = 5'h1f;
  localparam logic [14:0] REG_CMD = 15'h0000;
  localparam logic [14:0] REG_LEN = 15'h0004;
  localparam logic [14:0] REG_STAT = 15'h0008;
  localparam int MEM_SEL = 14;
  localparam int GO_BIT = 31;
  localparam int SB_BUSY = 0;
  localparam int SB_INH = 1;
  localparam int SB_INTR = 2;
  localparam int SB_ACK = 3;
  localparam int SB_ERR = 4;
  localparam int SB_CNT = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;

  function automatic logic [7:0] obph_crc8(input logic [7:0] c,
                                          input logic [LW-1:0] d);
    logic [7:0] r;
    r = c;
    for (int i = LW - 1; i >= 0; i--) begin
      r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction
endpackage

//--- obph_if.sv
// hardwired lines and optical slot signals between scheduler and port
`timescale 1ns/1ps
interface obph_if;
  logic poll;
  logic inhibit;
  logic ack;
  logic intr;
  logic [1:0] sync_code;
  logic ctl_valid;
  logic [15:0] ctl_word;
  logic dn_valid;
  logic dn_crc;
  logic dn_cls;
  logic [15:0] dn_data;
  logic up_valid;
  logic up_crc;
  logic up_cls;
  logic [15:0] up_data;

  modport port_end(
    input poll, sync_code, ctl_valid, ctl_word,
    input dn_valid, dn_crc, dn_cls, dn_data,
    output inhibit, ack, intr, up_valid, up_crc, up_cls, up_data
  );
  modport sched_end(
    output poll, sync_code, ctl_valid, ctl_word,
    output dn_valid, dn_crc, dn_cls, dn_data,
    input inhibit, ack, intr, up_valid, up_crc, up_cls, up_data
  );
endinterface

//--- obph_port.sv
// user data bus port: block buffer, crc and scheduler handshake
`timescale 1ns/1ps
// How it works
// - scheduler sends distinct control and data sync codes
// - scheduler has separate lines per port, sixteen; only one port's lines are built here
// - poll starts transmit if interrupting, else receive
// - scheduler polls only inside the sync slot
// - inhibit high while moving user data
// - acknowledge only after good crc on block
// - bad crc leaves acknowledge low; scheduler flags error
// - interrupt requests transmit, never with inhibit
// - stage user data; request when full or last
// - append 8-bit crc to every sent block
// - scheduler keeps command memory and port status
// - instructions come from control word and lines
// - only shared traffic class is used
// - blocks never exceed 2048 bits
// - user width programmable, serial to 32 bits
// - control word decoded only when polled
// - frame is sync, control, sync, data slots
// - crc only detects, never corrects
// - received data held in buffer until drained
module obph_port
  import obph_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  obph_if.port_end bus,
  input wire logic [UW-1:0] u_in_data,
  input wire logic u_in_valid,
  input wire logic u_in_last,
  output logic u_in_ready,
  output logic [UW-1:0] u_out_data,
  output logic u_out_valid,
  input wire logic u_out_ready,
  output logic [4:0] u_width_m1
);
  typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_READY, ST_WAIT, ST_TX,
    ST_RX, ST_DRAIN} obph_pst_t;

  obph_pst_t st_ff;
  obph_pst_t nxt_st;
  logic [BLK_BITS-1:0] buf_ff;
  logic [12:0] ptr_ff;
  logic [12:0] nbits_ff;
  logic [7:0] wcnt_ff;
  logic [7:0] crc_ff;
  logic [4:0] wid_ff;
  logic tx_mode_ff;
  logic dsync_ff;
  logic inhibit_ff;
  logic ack_ff;
  logic intr_ff;
  logic in_ready_ff;
  logic up_valid_ff;
  logic up_crc_ff;
  logic [LW-1:0] up_data_ff;
  logic out_valid_ff;
  logic [UW-1:0] out_data_ff;

  logic [12:0] wbits;
  logic [12:0] nxt_ptr;
  logic [7:0] nwords;
  logic [1:0] cw_cmd;
  logic [LW-1:0] tx_data;
  logic take_in;
  logic room;
  logic data_on;
  logic polled;
  logic rx_word;
  logic rx_end;
  logic crc_ok;
  logic tx_word;
  logic tx_tail;
  logic load_out;
  logic drain_done;

  assign wbits = {8'h0, wid_ff} + 13'h1;
  assign nxt_ptr = ptr_ff + wbits;
  assign nwords = 8'((ptr_ff + 13'hf) >> 4);
  assign cw_cmd = bus.ctl_word[CW_CMD_LSB +: 2];
  assign tx_data = buf_ff[wcnt_ff * LW +: LW];
  assign take_in = in_ready_ff && u_in_valid;
  assign room = int'(nxt_ptr + wbits) <= BLK_BITS;
  // data slot opens when the data sync code ends
  assign data_on = dsync_ff && bus.sync_code != SC_DATA;
  assign polled = bus.poll && bus.sync_code == SC_CTRL;
  assign rx_word = st_ff == ST_RX && data_on && bus.dn_valid &&
    bus.dn_cls == CLS_SHARED && int'(wcnt_ff) < BLK_WORDS;
  assign rx_end = st_ff == ST_RX && data_on && bus.dn_crc &&
    bus.dn_cls == CLS_SHARED;
  // mismatch holds acknowledge low and skips the drain; data is never repaired
  assign crc_ok = rx_end && wcnt_ff != 8'h0 &&
    bus.dn_data[7:0] == crc_ff;
  assign tx_word = st_ff == ST_TX && data_on && wcnt_ff < nwords;
  assign tx_tail = st_ff == ST_TX && data_on && wcnt_ff == nwords;
  assign load_out = st_ff == ST_DRAIN && ptr_ff < nbits_ff &&
    (!out_valid_ff || u_out_ready);
  assign drain_done = st_ff == ST_DRAIN && ptr_ff >= nbits_ff &&
    (!out_valid_ff || u_out_ready);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: begin
        // a beat already taken wins over a poll in the same cycle
        if (take_in) begin
          nxt_st = (u_in_last || !room) ? ST_READY : ST_FILL;
        end else if (polled) begin
          nxt_st = ST_WAIT;
        end
      end
      ST_FILL: begin
        if (take_in && (u_in_last || !room)) begin
          nxt_st = ST_READY;
        end
      end
      ST_READY: begin
        if (polled) begin
          nxt_st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (bus.ctl_valid) begin
          if (cw_cmd == CMD_TX && tx_mode_ff) begin
            nxt_st = ST_TX;
          end else if (cw_cmd == CMD_RX && !tx_mode_ff) begin
            nxt_st = ST_RX;
          end else begin
            nxt_st = tx_mode_ff ? ST_READY : ST_IDLE;
          end
        end
      end
      ST_TX: begin
        if (tx_tail) begin
          nxt_st = ST_IDLE;
        end
      end
      ST_RX: begin
        if (rx_end) begin
          nxt_st = crc_ok ? ST_DRAIN : ST_IDLE;
        end
      end
      ST_DRAIN: begin
        if (drain_done) begin
          nxt_st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= ST_IDLE;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_mode_ff <= 1'b0;
      wid_ff <= WID_RST;
      dsync_ff <= 1'b0;
    end else if (ce) begin
      if (nxt_st == ST_WAIT && st_ff != ST_WAIT) begin
        tx_mode_ff <= st_ff == ST_READY;
      end
      // only a polled port gets here, so others ignore the word
      if (st_ff == ST_WAIT && bus.ctl_valid) begin
        wid_ff <= bus.ctl_word[CW_WID_LSB +: 5];
      end
      dsync_ff <= (nxt_st == ST_TX || nxt_st == ST_RX) &&
        (dsync_ff || bus.sync_code == SC_DATA);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_ff <= 13'h0;
      nbits_ff <= 13'h0;
    end else if (ce) begin
      if (take_in) begin
        for (int i = 0; i < UW; i++) begin
          if (i <= int'(wid_ff) && int'(ptr_ff) + i < BLK_BITS) begin
            buf_ff[int'(ptr_ff) + i] <= u_in_data[i];
          end
        end
        ptr_ff <= nxt_ptr;
      end
      if (rx_word) begin
        buf_ff[wcnt_ff * LW +: LW] <= bus.dn_data;
      end
      if (rx_end) begin
        ptr_ff <= 13'h0;
        nbits_ff <= {1'b0, wcnt_ff, 4'h0};
      end
      if (load_out) begin
        ptr_ff <= nxt_ptr;
      end
      // emptying the buffer makes the next block fill from bit 0
      if (nxt_st == ST_IDLE && st_ff != ST_IDLE) begin
        ptr_ff <= 13'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcnt_ff <= 8'h0;
      crc_ff <= CRC_INIT;
    end else if (ce) begin
      if (st_ff == ST_WAIT) begin
        wcnt_ff <= 8'h0;
        crc_ff <= CRC_INIT;
      end else if (rx_word || tx_word) begin
        wcnt_ff <= wcnt_ff + 8'h1;
        crc_ff <= obph_crc8(crc_ff, rx_word ? bus.dn_data : tx_data);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_valid_ff <= 1'b0;
      up_crc_ff <= 1'b0;
      up_data_ff <= 16'h0;
    end else if (ce) begin
      up_valid_ff <= tx_word;
      up_crc_ff <= tx_tail;
      up_data_ff <= tx_word ? tx_data : (tx_tail ? {8'h0, crc_ff} : 16'h0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inhibit_ff <= 1'b0;
      intr_ff <= 1'b0;
      in_ready_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else if (ce) begin
      inhibit_ff <= nxt_st == ST_FILL || nxt_st == ST_DRAIN;
      // READY is never an inhibited state
      intr_ff <= nxt_st == ST_READY;
      in_ready_ff <= nxt_st == ST_IDLE || nxt_st == ST_FILL;
      if (nxt_st == ST_WAIT && st_ff != ST_WAIT) begin
        ack_ff <= 1'b0;
      end else if (crc_ok) begin
        ack_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 32'h0;
    end else if (ce) begin
      if (load_out) begin
        out_valid_ff <= 1'b1;
        for (int i = 0; i < UW; i++) begin
          out_data_ff[i] <= (i <= int'(wid_ff) &&
            int'(ptr_ff) + i < BLK_BITS) ? buf_ff[int'(ptr_ff) + i] : 1'b0;
        end
      end else if (u_out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

  assign bus.inhibit = inhibit_ff;
  assign bus.ack = ack_ff;
  assign bus.intr = intr_ff;
  assign bus.up_valid = up_valid_ff;
  assign bus.up_crc = up_crc_ff;
  assign bus.up_cls = CLS_SHARED;
  assign bus.up_data = up_data_ff;
  assign u_in_ready = in_ready_ff;
  assign u_out_data = out_data_ff;
  assign u_out_valid = out_valid_ff;
  assign u_width_m1 = wid_ff;
endmodule

//--- obph_sched.sv
// bus scheduler end: frame timing, poll, control word, axi registers
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module obph_sched
  import obph_pkg::*;
#(
  parameter int MEM_WORDS = CMD_BYTES / 4
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  obph_if.sched_end bus,
  input wire logic [14:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [14:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int MA = $clog2(MEM_WORDS);
  typedef enum logic [2:0] {SS_IDLE, SS_SYNC1, SS_CTRL, SS_SYNC2,
    SS_DATA} obph_sst_t;

  obph_sst_t st_ff;
  logic [31:0] mem [MEM_WORDS];
  logic [8:0] cnt_ff;
  logic [7:0] idx_ff;
  logic [7:0] len_ff;
  logic [6:0] cmd_ff;
  logic [7:0] crc_ff;
  logic go_ff;
  logic err_ff;
  logic good_ff;
  logic [14:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic poll_ff;
  logic [1:0] sync_ff;
  logic ctl_valid_ff;
  logic [15:0] ctl_word_ff;
  logic dn_valid_ff;
  logic dn_crc_ff;
  logic [15:0] dn_data_ff;
  logic [31:0] stat;
  logic wr_go;
  logic slot_end;
  logic in_data;
  logic send_word;
  logic send_crc;
  logic cap_word;

  assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
  assign slot_end = cnt_ff == 9'h0;
  assign in_data = st_ff == SS_DATA;
  assign send_word = in_data && cmd_ff[1:0] == CMD_RX && idx_ff < len_ff;
  assign send_crc = in_data && cmd_ff[1:0] == CMD_RX && idx_ff == len_ff;
  assign cap_word = in_data && cmd_ff[1:0] == CMD_TX && bus.up_valid &&
    int'(idx_ff) < BLK_WORDS;

  always_comb begin
    stat = 32'h0;
    stat[SB_BUSY] = st_ff != SS_IDLE;
    stat[SB_INH] = bus.inhibit;
    stat[SB_INTR] = bus.intr;
    stat[SB_ACK] = bus.ack;
    stat[SB_ERR] = err_ff;
    stat[SB_CNT +: 8] = idx_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= SS_IDLE;
      cnt_ff <= 9'h0;
    end else if (ce) begin
      unique case (st_ff)
        SS_IDLE: begin
          if (go_ff) begin
            st_ff <= SS_SYNC1;
            cnt_ff <= 9'(SYNC_CYC - 1);
          end
        end
        SS_SYNC1: begin
          if (slot_end) begin
            st_ff <= SS_CTRL;
            cnt_ff <= 9'(CTRL_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 9'h1;
          end
        end
        SS_CTRL: begin
          if (slot_end) begin
            st_ff <= SS_SYNC2;
            cnt_ff <= 9'(SYNC_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 9'h1;
          end
        end
        SS_SYNC2: begin
          if (slot_end) begin
            st_ff <= SS_DATA;
            cnt_ff <= 9'(DATA_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 9'h1;
          end
        end
        SS_DATA: begin
          if (slot_end) begin
            st_ff <= SS_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 9'h1;
          end
        end
      endcase
    end
  end

  // every line lags the state by one cycle, so they stay aligned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      poll_ff <= 1'b0;
      sync_ff <= SC_NONE;
      ctl_valid_ff <= 1'b0;
      ctl_word_ff <= 16'h0;
      dn_valid_ff <= 1'b0;
      dn_crc_ff <= 1'b0;
      dn_data_ff <= 16'h0;
    end else if (ce) begin
      poll_ff <= st_ff == SS_SYNC1;
      sync_ff <= st_ff == SS_SYNC1 ? SC_CTRL :
        (st_ff == SS_SYNC2 ? SC_DATA : SC_NONE);
      ctl_valid_ff <= st_ff == SS_CTRL && int'(cnt_ff) == CTRL_CYC - 1;
      ctl_word_ff <= {9'h0, cmd_ff};
      dn_valid_ff <= send_word;
      dn_crc_ff <= send_crc;
      dn_data_ff <= send_word ? mem[MA'(idx_ff)][LW-1:0] :
        {8'h0, crc_ff};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_ff <= 8'h0;
      crc_ff <= CRC_INIT;
      good_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (ce) begin
      if (st_ff == SS_SYNC2) begin
        idx_ff <= 8'h0;
        crc_ff <= CRC_INIT;
        good_ff <= 1'b0;
      end else if (send_word || send_crc) begin
        idx_ff <= idx_ff + 8'h1;
        if (send_word) begin
          crc_ff <= obph_crc8(crc_ff, mem[MA'(idx_ff)][LW-1:0]);
        end
      end else if (cap_word) begin
        idx_ff <= idx_ff + 8'h1;
        crc_ff <= obph_crc8(crc_ff, bus.up_data);
      end else if (in_data && bus.up_crc && bus.up_cls == CLS_SHARED) begin
        good_ff <= idx_ff != 8'h0 && bus.up_data[7:0] == crc_ff;
      end
      // missing acknowledge or bad crc at slot end is an error
      if (in_data && slot_end) begin
        err_ff <= cmd_ff[1:0] == CMD_RX ? !bus.ack :
          (cmd_ff[1:0] == CMD_TX ? !good_ff : 1'b0);
      end
    end
  end

  // capture wins; a bus write to memory in that cycle is dropped
  always_ff @(posedge aclk) begin
    if (ce) begin
      if (cap_word) begin
        mem[MA'(idx_ff)][LW-1:0] <= bus.up_data;
      end else if (wr_go && awaddr_ff[MEM_SEL]) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_ff[b]) begin
            mem[awaddr_ff[MA+1:2]][b*8 +: 8] <= wdata_ff[b*8 +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ff <= 7'h0;
      len_ff <= 8'h0;
      go_ff <= 1'b0;
    end else if (ce) begin
      if (wr_go && st_ff == SS_IDLE && !go_ff) begin
        if (awaddr_ff == REG_CMD) begin
          cmd_ff <= wdata_ff[6:0];
          go_ff <= wdata_ff[GO_BIT];
        end else if (awaddr_ff == REG_LEN) begin
          len_ff <= wdata_ff[7:0] > 8'(BLK_WORDS) ? 8'(BLK_WORDS) :
            wdata_ff[7:0];
        end
      end else if (st_ff == SS_IDLE && go_ff) begin
        go_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      awaddr_ff <= 15'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else if (ce) begin
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        if (s_axi_araddr[MEM_SEL]) begin
          rdata_ff <= mem[s_axi_araddr[MA+1:2]];
        end else if (s_axi_araddr == REG_CMD) begin
          rdata_ff <= {25'h0, cmd_ff};
        end else if (s_axi_araddr == REG_LEN) begin
          rdata_ff <= {24'h0, len_ff};
        end else if (s_axi_araddr == REG_STAT) begin
          rdata_ff <= stat;
        end else begin
          rdata_ff <= 32'h0;
        end
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // one port's line of the per-port set; only one port is built
  assign bus.poll = poll_ff;
  assign bus.sync_code = sync_ff;
  assign bus.ctl_valid = ctl_valid_ff;
  assign bus.ctl_word = ctl_word_ff;
  assign bus.dn_valid = dn_valid_ff;
  assign bus.dn_crc = dn_crc_ff;
  assign bus.dn_cls = CLS_SHARED;
  assign bus.dn_data = dn_data_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bresp = AXI_OKAY;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = AXI_OKAY;
  assign s_axi_rvalid = rvalid_ff;
endmodule

//--- obph_assertions.sv
// interface checker for the scheduler and port pair
`timescale 1ns/1ps
module obph_assertions
  import obph_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic poll,
  input wire logic inhibit,
  input wire logic ack,
  input wire logic intr,
  input wire logic [1:0] sync_code,
  input wire logic ctl_valid,
  input wire logic dn_crc,
  input wire logic up_valid,
  input wire logic up_crc,
  input wire logic up_cls
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [8:0] wc_ff;
  // words of the current upstream block, cleared by its crc word
  always_ff @(posedge aclk) begin
    if (!aresetn || up_crc) wc_ff <= 9'h0;
    else if (up_valid) wc_ff <= wc_ff + 9'h1;
  end
  sequence s_dsync;
    (sync_code == SC_DATA)[*8] ##32 (sync_code == SC_DATA);
  endsequence
  property p_poll; poll |-> sync_code == SC_CTRL; endproperty
  property p_intr; intr |-> !inhibit; endproperty
  property p_ack; $rose(ack) |-> $past(dn_crc); endproperty
  property p_cls; up_valid |-> up_cls == CLS_SHARED; endproperty
  property p_ctl;
    ctl_valid |-> ($past(sync_code) == SC_CTRL) ##18 (sync_code == SC_DATA);
  endproperty
  property p_dsync;
    $rose(sync_code == SC_DATA) |-> s_dsync ##1 (sync_code == SC_NONE);
  endproperty
  property p_words; up_valid |-> wc_ff < BLK_WORDS; endproperty
  property p_txend; up_crc |-> (!intr)[*8]; endproperty
  a_poll: assert property (p_poll) else $error("poll off slot");
  a_intr: assert property (p_intr) else $error("intr with inh");
  a_ack: assert property (p_ack) else $error("ack no crc");
  a_cls: assert property (p_cls) else $error("bad class");
  a_ctl: assert property (p_ctl) else $error("ctl slot");
  a_dsync: assert property (p_dsync) else $error("data sync");
  a_words: assert property (p_words) else $error("block long");
  a_txend: assert property (p_txend) else $error("intr held");
endmodule

//--- test_optical_bus_port_handshake.sv
// self-checking bench for the scheduler and port pair
`timescale 1ns/1ps
module test_optical_bus_port_handshake;
  import obph_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [14:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, u_in_data = 0, rd, s_axi_rdata, u_out_data;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1;
  logic u_in_valid = 0, u_in_last = 0, u_out_ready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, u_in_ready, u_out_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] u_width_m1;
  int bad_count = 0, n_checks = 0, seed = 79715;
  int wt[3] = '{0, 7, 15};
  logic [15:0] mem [128];
  logic [31:0] got [$];
  obph_if bus ();
  obph_sched u_obph_sched (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .bus(bus), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  obph_port u_obph_port (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .bus(bus), .u_in_data(u_in_data), .u_in_valid(u_in_valid),
    .u_in_last(u_in_last), .u_in_ready(u_in_ready),
    .u_out_data(u_out_data), .u_out_valid(u_out_valid),
    .u_out_ready(u_out_ready), .u_width_m1(u_width_m1));
  obph_assertions u_obph_assertions (.aclk(aclk), .aresetn(aresetn),
    .poll(bus.poll), .inhibit(bus.inhibit), .ack(bus.ack),
    .intr(bus.intr), .sync_code(bus.sync_code), .ctl_valid(bus.ctl_valid),
    .dn_crc(bus.dn_crc), .up_valid(bus.up_valid), .up_crc(bus.up_crc),
    .up_cls(bus.up_cls));
  always #50 aclk = ~aclk;
  // random stalls on the user drain side
  always @(posedge aclk) begin
    u_out_ready <= 1'($random(seed));
    if (u_out_valid && u_out_ready) got.push_back(u_out_data);
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo();
    bad_count++;
    $display("Error timeout expected done seen hang");
    final_report();
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic axw(input logic [14:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (++n > 50) tmo();
    end while (!s_axi_bvalid);
    chk("bresp", s_axi_bresp, AXI_OKAY);
  endtask
  task automatic axr(input logic [14:0] a, output logic [31:0] d);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (++n > 50) tmo();
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk("rresp", s_axi_rresp, AXI_OKAY);
  endtask
  task automatic stat_wait(input int b, input logic v);
    int n;
    n = 0;
    do begin
      axr(REG_STAT, rd);
      if (++n > 2000) tmo();
    end while (rd[b] !== v);
  endtask
  // beat k of width w, lowest buffer bits first
  function automatic logic [31:0] beat(int k, int w);
    logic [31:0] v;
    v = 0;
    for (int i = 0; i < w; i++) begin
      v[i] = mem[(k * w + i) / 16][(k * w + i) % 16];
    end
    return v;
  endfunction
  // reference crc x^8+x^2+x+1 from zero, word msb first
  function automatic logic [7:0] ref_crc(logic [7:0] c, logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  logic [7:0] tcrc = 8'h00;
  // the port's crc word is judged apart from the shared helper
  always @(posedge aclk) begin
    if (bus.up_valid) tcrc <= ref_crc(tcrc, bus.up_data);
    if (bus.up_crc) begin
      chk("upcrc", bus.up_data, {8'h00, tcrc});
      tcrc <= 8'h00;
    end
  end
  initial begin
    int n, w, c;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("width", u_width_m1, 5'h1f);
    axr(REG_STAT, rd);
    chk("stat", rd[4:0], 5'h0);
    axr(15'h0010, rd);
    chk("unmapped", rd, 32'h0);
    // enable low: an offered last beat must not be taken
    ce <= 0;
    u_in_valid <= 1;
    u_in_last <= 1;
    repeat (3) @(posedge aclk);
    ce <= 1;
    u_in_valid <= 0;
    u_in_last <= 0;
    axr(REG_STAT, rd);
    chk("frozen", rd[SB_INTR], 1'b0);
    for (int t = 0; t < 3; t++) begin
      w = wt[t] + 1;
      n = (t == 2) ? 128 : 1 + ({$random(seed)} % 8);
      for (int k = 0; k < n; k++) begin
        mem[k] = 16'($random(seed));
        axw(15'h4000 + 15'(k * 4), {16'h0, mem[k]});
      end
      axw(REG_LEN, 32'(n));
      got.delete();
      axw(REG_CMD, 32'h80000000 | 32'(wt[t] << 2) | 32'(CMD_RX));
      stat_wait(SB_BUSY, 1'b0);
      axr(REG_STAT, rd);
      chk("ack", rd[SB_ACK], 1'b1);
      chk("err", rd[SB_ERR], 1'b0);
      c = 0;
      while (got.size() < n * 16 / w) begin
        @(posedge aclk);
        if (++c > 5000) tmo();
      end
      chk("width", u_width_m1, 5'(wt[t]));
      for (int k = 0; k < n * 16 / w; k++) begin
        chk("beat", got[k], beat(k, w));
      end
    end
    // transmit order with nothing staged: port falls back, no block
    axw(REG_CMD, 32'h80000000 | 32'(15 << 2) | 32'(CMD_TX));
    stat_wait(SB_BUSY, 1'b0);
    chk("err", rd[SB_ERR], 1'b1);
    chk("ack", rd[SB_ACK], 1'b0);
    // transmit: short block ended by last, then a full buffer
    for (int t = 0; t < 2; t++) begin
      n = t ? 128 : 1 + ({$random(seed)} % 8);
      for (int k = 0; k < n; k++) begin
        mem[k] = 16'($random(seed));
        u_in_data <= {16'h0, mem[k]};
        u_in_valid <= 1;
        u_in_last <= (k == n - 1) && (n < 128);
        c = 0;
        do begin
          @(posedge aclk);
          if (++c > 50) tmo();
        end while (!u_in_ready);
      end
      u_in_valid <= 0;
      stat_wait(SB_INTR, 1'b1);
      chk("inh", rd[SB_INH], 1'b0);
      axw(REG_CMD, 32'h80000000 | 32'(15 << 2) | 32'(CMD_TX));
      stat_wait(SB_BUSY, 1'b0);
      chk("err", rd[SB_ERR], 1'b0);
      chk("intr", rd[SB_INTR], 1'b0);
      for (int k = 0; k < n; k++) begin
        axr(15'h4000 + 15'(k * 4), rd);
        chk("txword", rd[15:0], mem[k]);
      end
    end
    final_report();
  end
endmodule
